// ---- inc/bms_consts.vh ----
`ifndef BMS_CONSTS_VH
`define BMS_CONSTS_VH

// ==========================================================
// boot modes
`define BMS_MODE_W        3
`define BMS_MODE_NONE     3'h0
`define BMS_MODE_EPROM    3'h1
`define BMS_MODE_HOST     3'h2
`define BMS_MODE_LINK     3'h3
`define BMS_MODE_RSVD     3'h7

// ==========================================================
// register map (byte addresses)
`define BMS_ADDR_W        4
`define BMS_OFS_STATUS    4'h0
`define BMS_OFS_CTRL      4'h4
`define BMS_OFS_STRAPS    4'h8

// ==========================================================
// field positions
`define BMS_ST_FIRST_LSB  0
`define BMS_ST_GROUP_LSB  4
`define BMS_ST_FIRST_RSVD 8
`define BMS_ST_GROUP_RSVD 9
`define BMS_CTRL_W        2
`define BMS_CTRL_EN_FIRST 0
`define BMS_CTRL_EN_GROUP 1
`define BMS_CTRL_RST      2'h3
`define BMS_STRAP_W       6

// ==========================================================
// bus answers
`define BMS_RESP_OKAY     2'h0
`define BMS_RESP_SLVERR   2'h2
`define BMS_DATA_ZERO     32'h00000000

`endif

// ---- verilog/bms_sync3.v ----
`timescale 1ns/1ps
`include "bms_consts.vh"

// ==========================================================
// three-stage strap synchroniser
// a bit changes once stages two and three agree; no reset so the
// chain keeps filling while the module reset is held
module bms_sync3 #(
  parameter W = `BMS_STRAP_W
) (
  input  wire         clk_in,
  input  wire [W-1:0] async_in,
  output wire [W-1:0] stable_out
);

  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  reg [W-1:0] stable_r;

  always @(posedge clk_in) begin
    s1_r <= async_in;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // per bit: take the new level only when both late stages agree
  always @(posedge clk_in) begin
    stable_r <= (s2_r & ~(s2_r ^ s3_r)) | (stable_r & (s2_r ^ s3_r));
  end

  assign stable_out = stable_r;

endmodule // bms_sync3

// ---- verilog/bms_mode_decode.v ----
`timescale 1ns/1ps
`include "bms_consts.vh"

// ==========================================================
// strap decoder, shared by the first processor and the group
module bms_mode_decode (
  input  wire                   eprom_boot_select_in,
  input  wire                   link_boot_select_in,
  input  wire                   boot_mem_sel_in,
  output reg  [`BMS_MODE_W-1:0] mode_out,
  output reg                    reserved_out,
  output reg                    cs_output_out
);

  always @* begin
    mode_out      = `BMS_MODE_RSVD;
    reserved_out  = 1'b1;
    cs_output_out = 1'b0;
    case ({eprom_boot_select_in, link_boot_select_in})
      2'h2: begin
        // R1 eprom boot
        mode_out      = `BMS_MODE_EPROM;
        reserved_out  = 1'b0;
        // R5 pin turns output
        cs_output_out = 1'b1;
      end
      2'h1: begin
        // R3 R11 link boot
        if (boot_mem_sel_in) begin
          mode_out     = `BMS_MODE_LINK;
          reserved_out = 1'b0;
        end
      end
      2'h0: begin
        // R4 R10 host boot
        reserved_out = 1'b0;
        if (boot_mem_sel_in) begin
          mode_out = `BMS_MODE_HOST;
        end else begin
          // R7 run from external memory
          mode_out = `BMS_MODE_NONE;
        end
      end
      default: begin
        // R12 reserved code
        mode_out     = `BMS_MODE_RSVD;
        reserved_out = 1'b1;
      end
    endcase
  end

endmodule // bms_mode_decode

// ---- verilog/bms_boot_mode_select.v ----
`timescale 1ns/1ps
`include "bms_consts.vh"

// Function
// R1: eprom select high gives 8-bit eprom boot
// R2: eprom select low: link and memory-select decide
// R3: link select high gives link port boot
// R4: link select low gives host or no boot
// R5: memory-select pin outputs only in eprom boot
// R6: only bus master drives the chip select
// R7: memory-select input low: execute external memory
// R8: group straps decide jointly for three processors
// R9: system ties straps to fixed levels
// R10: code 0,0,1 selects host boot
// R11: code 0,1,1 selects link port boot
// R12: codes 0,1,0 and 1,1,x are reserved
// R13: sample during reset, hold until next reset

// ==========================================================
// boot-mode selection with register access
module bms_boot_mode_select #(
  parameter AXI_ADDR_W = `BMS_ADDR_W
) (
  input  wire                   clk_in,
  input  wire                   rst_in,
  input  wire                   eprom_boot_sel_first_in,
  input  wire                   link_boot_sel_first_in,
  input  wire                   boot_mem_sel_first_in,
  output wire                   boot_mem_sel_first_out,
  output wire                   boot_mem_sel_first_oe_out,
  input  wire                   eprom_boot_sel_group_in,
  input  wire                   link_boot_sel_group_in,
  input  wire                   boot_mem_sel_group_in,
  output wire                   boot_mem_sel_group_out,
  output wire                   boot_mem_sel_group_oe_out,
  input  wire                   bus_master_first_in,
  input  wire                   bus_master_group_in,
  input  wire                   eprom_cs_n_first_in,
  input  wire                   eprom_cs_n_group_in,
  output wire [`BMS_MODE_W-1:0] boot_mode_first_out,
  output wire [`BMS_MODE_W-1:0] boot_mode_group_out,
  output wire                   exec_ext_first_out,
  output wire                   exec_ext_group_out,
  input  wire [AXI_ADDR_W-1:0]  s_axi_awaddr,
  input  wire [2:0]             s_axi_awprot,
  input  wire                   s_axi_awvalid,
  output wire                   s_axi_awready,
  input  wire [31:0]            s_axi_wdata,
  input  wire [3:0]             s_axi_wstrb,
  input  wire                   s_axi_wvalid,
  output wire                   s_axi_wready,
  output wire [1:0]             s_axi_bresp,
  output wire                   s_axi_bvalid,
  input  wire                   s_axi_bready,
  input  wire [AXI_ADDR_W-1:0]  s_axi_araddr,
  input  wire [2:0]             s_axi_arprot,
  input  wire                   s_axi_arvalid,
  output wire                   s_axi_arready,
  output wire [31:0]            s_axi_rdata,
  output wire [1:0]             s_axi_rresp,
  output wire                   s_axi_rvalid,
  input  wire                   s_axi_rready
);

  // ==========================================================
  // strap synchronisation
  // R9 straps assumed static; the chain tolerates bounce mid-reset that settles at least five clocks before release
  wire [`BMS_STRAP_W-1:0] strap_raw;
  wire [`BMS_STRAP_W-1:0] strap_sync;

  assign strap_raw = {eprom_boot_sel_group_in, link_boot_sel_group_in,
                      boot_mem_sel_group_in, eprom_boot_sel_first_in,
                      link_boot_sel_first_in, boot_mem_sel_first_in};

  bms_sync3 #(
    .W          (`BMS_STRAP_W)
  ) u_sync (
    .clk_in     (clk_in),
    .async_in   (strap_raw),
    .stable_out (strap_sync)
  );

  // ==========================================================
  // decoding
  wire [`BMS_MODE_W-1:0] dec_mode_first;
  wire [`BMS_MODE_W-1:0] dec_mode_group;
  wire                   dec_rsvd_first;
  wire                   dec_rsvd_group;
  wire                   dec_csout_first;
  wire                   dec_csout_group;

  // one decoder module for both, so the two cannot drift apart
  // R2 first processor decode
  bms_mode_decode u_dec_first (
    .eprom_boot_select_in (strap_sync[2]),
    .link_boot_select_in  (strap_sync[1]),
    .boot_mem_sel_in      (strap_sync[0]),
    .mode_out             (dec_mode_first),
    .reserved_out         (dec_rsvd_first),
    .cs_output_out        (dec_csout_first)
  );

  // R8 one decode for the group
  bms_mode_decode u_dec_group (
    .eprom_boot_select_in (strap_sync[5]),
    .link_boot_select_in  (strap_sync[4]),
    .boot_mem_sel_in      (strap_sync[3]),
    .mode_out             (dec_mode_group),
    .reserved_out         (dec_rsvd_group),
    .cs_output_out        (dec_csout_group)
  );

  // ==========================================================
  // latched boot mode
  reg [`BMS_MODE_W-1:0]  mode_first_r;
  reg [`BMS_MODE_W-1:0]  mode_group_r;
  reg                    rsvd_first_r;
  reg                    rsvd_group_r;
  reg                    csout_first_r;
  reg                    csout_group_r;
  reg                    exec_first_r;
  reg                    exec_group_r;
  reg [`BMS_STRAP_W-1:0] strap_cap_r;

  // no reset value: reset itself loads the decoded straps
  // R13 track straps in reset, freeze after release
  always @(posedge clk_in) begin
    if (rst_in) begin
      mode_first_r  <= dec_mode_first;
      mode_group_r  <= dec_mode_group;
      rsvd_first_r  <= dec_rsvd_first;
      rsvd_group_r  <= dec_rsvd_group;
      csout_first_r <= dec_csout_first;
      csout_group_r <= dec_csout_group;
      strap_cap_r   <= strap_sync;
      // R7 no boot: fetch from external memory
      exec_first_r  <= (dec_mode_first == `BMS_MODE_NONE);
      exec_group_r  <= (dec_mode_group == `BMS_MODE_NONE);
    end
  end

  // ==========================================================
  // chip-select drive
  reg                    ctrl_en_first_r;
  reg                    ctrl_en_group_r;
  reg                    cs_first_r;
  reg                    cs_group_r;
  reg                    oe_first_r;
  reg                    oe_group_r;
  wire                   drive_first;
  wire                   drive_group;

  // R5 R6 output only in eprom boot and as master
  assign drive_first = csout_first_r & bus_master_first_in & ctrl_en_first_r;
  assign drive_group = csout_group_r & bus_master_group_in & ctrl_en_group_r;
  // registered drive lags a mastership change by one cycle; the
  // arbiter must leave that turn-around before a new master drives

  always @(posedge clk_in) begin
    if (rst_in) begin
      cs_first_r <= 1'b1;
      cs_group_r <= 1'b1;
      oe_first_r <= 1'b0;
      oe_group_r <= 1'b0;
    end else begin
      // R6 released pin idles high, undriven
      oe_first_r <= drive_first;
      oe_group_r <= drive_group;
      cs_first_r <= drive_first ? eprom_cs_n_first_in : 1'b1;
      cs_group_r <= drive_group ? eprom_cs_n_group_in : 1'b1;
    end
  end

  // ==========================================================
  // axi4-lite write channel
  reg                    awready_r;
  reg                    wready_r;
  reg                    bvalid_r;
  reg [1:0]              bresp_r;
  reg [AXI_ADDR_W-1:0]   wr_addr_r;
  reg [31:0]             wr_data_r;
  reg                    wr_strb0_r;

  always @(posedge clk_in) begin
    if (rst_in) begin
      awready_r       <= 1'b1;
      wready_r        <= 1'b1;
      bvalid_r        <= 1'b0;
      bresp_r         <= `BMS_RESP_OKAY;
      wr_addr_r       <= {AXI_ADDR_W{1'b0}};
      wr_data_r       <= `BMS_DATA_ZERO;
      wr_strb0_r      <= 1'b0;
      ctrl_en_first_r <= 1'b1;
      ctrl_en_group_r <= 1'b1;
    end else begin
      // address and data in either order; each parks until both
      if (s_axi_awvalid && awready_r) begin
        awready_r <= 1'b0;
        wr_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r) begin
        wready_r   <= 1'b0;
        wr_data_r  <= s_axi_wdata;
        // only byte lane 0 carries the enables
        wr_strb0_r <= s_axi_wstrb[0];
      end
      // both halves held: commit and answer next edge
      if (!awready_r && !wready_r && !bvalid_r) begin
        bvalid_r <= 1'b1;
        if (wr_addr_r == `BMS_OFS_CTRL) begin
          bresp_r <= `BMS_RESP_OKAY;
          // lane 0 unstrobed: enables untouched, still okay
          if (wr_strb0_r) begin
            ctrl_en_first_r <= wr_data_r[`BMS_CTRL_EN_FIRST];
            ctrl_en_group_r <= wr_data_r[`BMS_CTRL_EN_GROUP];
          end
        end else if (wr_addr_r == `BMS_OFS_STATUS ||
                     wr_addr_r == `BMS_OFS_STRAPS) begin
          // read-only words take the write silently
          bresp_r <= `BMS_RESP_OKAY;
        end else begin
          bresp_r <= `BMS_RESP_SLVERR;
        end
      end
      // ready returns only after the response: one write at a time
      if (bvalid_r && s_axi_bready) begin
        bvalid_r  <= 1'b0;
        awready_r <= 1'b1;
        wready_r  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // axi4-lite read channel
  reg                    arready_r;
  reg                    rvalid_r;
  reg [31:0]             rdata_r;
  reg [1:0]              rresp_r;
  reg [31:0]             rd_word;
  reg                    rd_hit;

  always @* begin
    rd_word = `BMS_DATA_ZERO;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `BMS_OFS_STATUS: begin
        rd_word[`BMS_ST_FIRST_LSB +: `BMS_MODE_W] = mode_first_r;
        rd_word[`BMS_ST_GROUP_LSB +: `BMS_MODE_W] = mode_group_r;
        // R12 reserved code visible to software
        rd_word[`BMS_ST_FIRST_RSVD] = rsvd_first_r;
        rd_word[`BMS_ST_GROUP_RSVD] = rsvd_group_r;
      end
      `BMS_OFS_CTRL: begin
        rd_word[`BMS_CTRL_EN_FIRST] = ctrl_en_first_r;
        rd_word[`BMS_CTRL_EN_GROUP] = ctrl_en_group_r;
      end
      `BMS_OFS_STRAPS: begin
        rd_word[`BMS_STRAP_W-1:0] = strap_cap_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge clk_in) begin
    if (rst_in) begin
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= `BMS_DATA_ZERO;
      rresp_r   <= `BMS_RESP_OKAY;
    end else begin
      // rdata frozen at the address edge, stands until rready
      if (s_axi_arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_word;
        rresp_r   <= rd_hit ? `BMS_RESP_OKAY : `BMS_RESP_SLVERR;
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r  <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  // ==========================================================
  // outputs
  // every port is a flip-flop, no logic after the register
  assign boot_mem_sel_first_out    = cs_first_r;
  assign boot_mem_sel_first_oe_out = oe_first_r;
  assign boot_mem_sel_group_out    = cs_group_r;
  assign boot_mem_sel_group_oe_out = oe_group_r;
  assign boot_mode_first_out       = mode_first_r;
  assign boot_mode_group_out       = mode_group_r;
  assign exec_ext_first_out        = exec_first_r;
  assign exec_ext_group_out        = exec_group_r;
  assign s_axi_awready             = awready_r;
  assign s_axi_wready              = wready_r;
  assign s_axi_bvalid              = bvalid_r;
  assign s_axi_bresp               = bresp_r;
  assign s_axi_arready             = arready_r;
  assign s_axi_rvalid              = rvalid_r;
  assign s_axi_rdata               = rdata_r;
  assign s_axi_rresp               = rresp_r;

endmodule // bms_boot_mode_select

// ---- verification/bms_far_model.sv ----
`timescale 1ns/1ps

// ==========================================================
// strap wiring and memory-select pin of one processor group
module bms_far_model (
  input  wire [2:0] code_in,
  input  wire       pin_out_in,
  input  wire       pin_oe_in,
  output wire       eprom_boot_out,
  output wire       link_boot_out,
  output wire       mem_sel_out,
  output wire       pin_level_out
);
  assign eprom_boot_out = code_in[2];
  assign link_boot_out  = code_in[1];
  // pin carries cs only while driven, else strap level
  assign pin_level_out  = pin_oe_in ? pin_out_in : code_in[0];
  assign mem_sel_out    = pin_level_out;
endmodule // bms_far_model

// ---- verification/bms_boot_mode_select_asserts.sv ----
`timescale 1ns/1ps
`include "bms_consts.vh"

// ==========================================================
// port checker
module bms_checks (
  input wire                   clk_in,
  input wire                   rst_in,
  input wire                   bus_master_first_in,
  input wire                   bus_master_group_in,
  input wire                   eprom_cs_n_first_in,
  input wire                   boot_mem_sel_first_out,
  input wire                   boot_mem_sel_first_oe_out,
  input wire                   boot_mem_sel_group_oe_out,
  input wire [`BMS_MODE_W-1:0] boot_mode_first_out,
  input wire [`BMS_MODE_W-1:0] boot_mode_group_out,
  input wire                   exec_ext_first_out,
  input wire                   exec_ext_group_out,
  input wire                   s_axi_arready,
  input wire                   s_axi_rvalid,
  input wire                   s_axi_rready
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_first_mode_frozen: assert property (
    !$past(rst_in) |-> $stable(boot_mode_first_out))
    else $error("first mode changed after reset");
  a_group_mode_frozen: assert property (
    !$past(rst_in) |-> $stable(boot_mode_group_out))
    else $error("group mode changed after reset");
  a_first_exec_ext: assert property (
    exec_ext_first_out == (boot_mode_first_out == `BMS_MODE_NONE))
    else $error("first exec flag wrong");
  a_group_exec_ext: assert property (
    exec_ext_group_out == (boot_mode_group_out == `BMS_MODE_NONE))
    else $error("group exec flag wrong");
  a_oe_eprom_only: assert property (
    boot_mem_sel_first_oe_out |-> boot_mode_first_out == `BMS_MODE_EPROM)
    else $error("pin driven outside eprom boot");
  a_oe_needs_master: assert property (
    boot_mem_sel_first_oe_out |-> $past(bus_master_first_in))
    else $error("first pin driven without bus mastership");
  a_grp_needs_master: assert property (
    boot_mem_sel_group_oe_out |-> $past(bus_master_group_in))
    else $error("group pin driven without bus mastership");
  a_cs_idle_high: assert property (
    !boot_mem_sel_first_oe_out |-> boot_mem_sel_first_out)
    else $error("chip select low while released");
  a_cs_follows_req: assert property (
    boot_mem_sel_first_oe_out |->
      boot_mem_sel_first_out == $past(eprom_cs_n_first_in))
    else $error("chip select does not follow request");
  a_read_blocks_ar: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken during pending read");
  a_read_ends: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not retired");
endmodule // bms_checks

bind bms_boot_mode_select bms_checks i_chk (
  .clk_in, .rst_in, .bus_master_first_in, .bus_master_group_in,
  .eprom_cs_n_first_in, .boot_mem_sel_first_out,
  .boot_mem_sel_first_oe_out, .boot_mem_sel_group_oe_out,
  .boot_mode_first_out, .boot_mode_group_out, .exec_ext_first_out,
  .exec_ext_group_out, .s_axi_arready, .s_axi_rvalid, .s_axi_rready
);

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
`include "bms_consts.vh"

// ==========================================================
// testbench
module tb_top;
  reg         clk_in = 1'h0;
  reg         rst_in = 1'h1;
  reg  [2:0]  cf = 3'h0;
  reg  [2:0]  cg = 3'h0;
  reg  [2:0]  xf;
  reg  [2:0]  xg;
  reg         bm_f = 1'h0;
  reg         bm_g = 1'h0;
  reg         csn_f = 1'h1;
  reg         csn_g = 1'h1;
  reg  [3:0]  awaddr = 4'h0;
  reg  [3:0]  araddr = 4'h0;
  reg  [31:0] wdata = `BMS_DATA_ZERO;
  reg  [3:0]  wstrb = 4'hF;
  reg         awvalid = 1'h0;
  reg         wvalid = 1'h0;
  reg         arvalid = 1'h0;
  reg  [31:0] rd;
  reg  [1:0]  rs;
  reg         a_p;
  reg         w_p;
  wire        eb_f, lb_f, ms_f, pin_f, cs_f, oe_f, ex_f;
  wire        eb_g, lb_g, ms_g, pin_g, cs_g, oe_g, ex_g;
  wire [2:0]  md_f, md_g;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  integer     err_total = 0;
  integer     comparisons = 0;
  integer     i;

  always #12.5 clk_in = ~clk_in;

  bms_far_model i_far_f (.code_in(cf), .pin_out_in(cs_f),
    .pin_oe_in(oe_f), .eprom_boot_out(eb_f), .link_boot_out(lb_f),
    .mem_sel_out(ms_f), .pin_level_out(pin_f));
  bms_far_model i_far_g (.code_in(cg), .pin_out_in(cs_g),
    .pin_oe_in(oe_g), .eprom_boot_out(eb_g), .link_boot_out(lb_g),
    .mem_sel_out(ms_g), .pin_level_out(pin_g));

  bms_boot_mode_select i_dut (.clk_in(clk_in), .rst_in(rst_in),
    .eprom_boot_sel_first_in(eb_f), .link_boot_sel_first_in(lb_f),
    .boot_mem_sel_first_in(ms_f), .boot_mem_sel_first_out(cs_f),
    .boot_mem_sel_first_oe_out(oe_f), .eprom_boot_sel_group_in(eb_g),
    .link_boot_sel_group_in(lb_g), .boot_mem_sel_group_in(ms_g),
    .boot_mem_sel_group_out(cs_g), .boot_mem_sel_group_oe_out(oe_g),
    .bus_master_first_in(bm_f), .bus_master_group_in(bm_g),
    .eprom_cs_n_first_in(csn_f), .eprom_cs_n_group_in(csn_g),
    .boot_mode_first_out(md_f), .boot_mode_group_out(md_g),
    .exec_ext_first_out(ex_f), .exec_ext_group_out(ex_g),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'h1), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'h1));

  function [2:0] em(input [2:0] c);
    em = c[2] ? (c[1] ? `BMS_MODE_RSVD : `BMS_MODE_EPROM) :
         c[1] ? (c[0] ? `BMS_MODE_LINK : `BMS_MODE_RSVD) :
         (c[0] ? `BMS_MODE_HOST : `BMS_MODE_NONE);
  endfunction

  task tally_and_finish;
    begin
      if (err_total == 0 && comparisons > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task chk(input [31:0] g, input [31:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  // bready and rready stay high, so the answer edge ends each access
  task wr(input [3:0] a, input [31:0] d);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      a_p = 1'h1;
      w_p = 1'h1;
      while (a_p || w_p) begin
        @(posedge clk_in);
        if (a_p && awready) begin
          a_p = 1'h0;
          awvalid <= 1'h0;
        end
        if (w_p && wready) begin
          w_p = 1'h0;
          wvalid <= 1'h0;
        end
      end
      do @(posedge clk_in); while (!bvalid);
      rs = bresp;
    end
  endtask

  task rdr(input [3:0] a);
    begin
      araddr <= a;
      arvalid <= 1'h1;
      do @(posedge clk_in); while (!arready);
      arvalid <= 1'h0;
      do @(posedge clk_in); while (!rvalid);
      rd = rdata;
      rs = rresp;
    end
  endtask

  task boot(input [2:0] f, input [2:0] g);
    begin
      cf <= f;
      cg <= g;
      rst_in <= 1'h1;
      repeat (16) @(posedge clk_in);
      rst_in <= 1'h0;
      repeat (2) @(posedge clk_in);
    end
  endtask

  // ==========================================================
  // tests
  initial begin
    for (i = 0; i < 8; i = i + 1) begin
      xf = i[2:0];
      xg = ~xf;
      boot(xf, xg);
      chk(32'(md_f), 32'(em(xf)));
      chk(32'(md_g), 32'(em(xg)));
      chk(32'(ex_f), 32'(em(xf) == `BMS_MODE_NONE));
      chk(32'(ex_g), 32'(em(xg) == `BMS_MODE_NONE));
      rdr(`BMS_OFS_STATUS);
      chk(rd, {22'h0, em(xg) == 3'h7, em(xf) == 3'h7, 1'h0, em(xg),
        1'h0, em(xf)});
      rdr(`BMS_OFS_STRAPS);
      chk(rd, {26'h0, xg, xf});
      cf <= xg;
      cg <= xf;
      repeat (6) @(posedge clk_in);
      chk(32'(md_f), 32'(em(xf)));
      chk(32'(md_g), 32'(em(xg)));
    end
    // eprom boot: pin drive follows mastership and enables
    boot(3'h5, 3'h5);
    rdr(`BMS_OFS_CTRL);
    chk(rd, 32'(`BMS_CTRL_RST));
    csn_f <= 1'h0;
    csn_g <= 1'h0;
    bm_f <= 1'h1;
    bm_g <= 1'h1;
    repeat (3) @(posedge clk_in);
    chk(32'(oe_f), 32'h1);
    chk(32'(pin_f), 32'h0);
    chk(32'(oe_g), 32'h1);
    chk(32'(pin_g), 32'h0);
    bm_f <= 1'h0;
    repeat (3) @(posedge clk_in);
    chk(32'(oe_f), 32'h0);
    chk(32'(pin_f), 32'h1);
    wr(`BMS_OFS_CTRL, 32'h00000001);
    chk(32'(rs), 32'(`BMS_RESP_OKAY));
    repeat (2) @(posedge clk_in);
    chk(32'(oe_g), 32'h0);
    chk(32'(pin_g), 32'h1);
    wr(`BMS_OFS_CTRL, 32'h00000003);
    repeat (2) @(posedge clk_in);
    chk(32'(oe_g), 32'h1);
    chk(32'(pin_g), 32'h0);
    // low byte-0 strobe must leave the enables alone
    wstrb <= 4'hE;
    wr(`BMS_OFS_CTRL, `BMS_DATA_ZERO);
    wstrb <= 4'hF;
    chk(32'(rs), 32'(`BMS_RESP_OKAY));
    rdr(`BMS_OFS_CTRL);
    chk(rd, 32'(`BMS_CTRL_RST));
    rdr(4'hC);
    chk(32'(rs), 32'(`BMS_RESP_SLVERR));
    chk(rd, `BMS_DATA_ZERO);
    wr(4'hC, 32'h00000001);
    chk(32'(rs), 32'(`BMS_RESP_SLVERR));
    wr(`BMS_OFS_STATUS, 32'hFFFFFFFF);
    chk(32'(rs), 32'(`BMS_RESP_OKAY));
    rdr(`BMS_OFS_STATUS);
    chk(rd, 32'h00000011);
    tally_and_finish;
  end

  initial begin
    repeat (4000) @(posedge clk_in);
    err_total = err_total + 1;
    tally_and_finish;
  end
endmodule // tb_top
